// >>> rtl/ltc_defines.svh
// Contract
// RULE1: Red short threshold code, word0 bits 41:39
// RULE2: Green short threshold code, word0 bits 44:42
// RULE3: Blue short threshold code, word0 bits 47:45
// RULE4: Word1 bit 1 picks 10 or 40 mA
// RULE5: Word1 bit 14 flips upper line order
// RULE6: Word1 bits 16-18 enable fine compensation
// RULE7: Word1 bits 19-21 select turn-off slew rate
// RULE8: Word1 two-bit turn-on slew fields, reset 01
// RULE9: Word1 bits 32-34 enable coarse compensation
// RULE10: Word1 bits 38:35 first line dim code
// RULE11: Word1 bit 39 enables on/off isolation
// RULE12: Panel size bit selects single or stacked
// RULE13: Reserved bits fixed; fields read back written
// RULE14: Fields drive stored values continuously
`ifndef LTC_DEFINES_SVH
`define LTC_DEFINES_SVH

// ----------------------------------------------------------------
// APB byte offsets
// ----------------------------------------------------------------
`define LTC_PROT_LO_OFS  8'h00
`define LTC_PROT_HI_OFS  8'h04
`define LTC_DRV_LO_OFS   8'h08
`define LTC_DRV_HI_OFS   8'h0C
`define LTC_PANEL_OFS    8'h10
`define LTC_STATUS_OFS   8'h14

// ----------------------------------------------------------------
// Reset values and writable masks of the 48-bit words, and the panel bit reset value
// ----------------------------------------------------------------
`define LTC_PROT_RST     48'h003B_7F7F_7F00
`define LTC_PROT_WMASK   48'hFFFF_FFFF_FFBF
`define LTC_DRV_RST      48'h0800_0540_403C
`define LTC_DRV_WMASK    48'h1FFF_0FFF_4002
`define LTC_PANEL_RST    1'h0

// ----------------------------------------------------------------
// Field positions (least significant bit)
// ----------------------------------------------------------------
`define LTC_RED_THR_POS     39
`define LTC_GRN_THR_POS     42
`define LTC_BLU_THR_POS     45
`define LTC_CEIL_POS        1
`define LTC_FLIP_POS        14
`define LTC_FINE_POS        16
`define LTC_FALL_POS        19
`define LTC_RISE_R_POS      22
`define LTC_RISE_G_POS      24
`define LTC_RISE_B_POS      26
`define LTC_COARSE_POS      32
`define LTC_DIM_POS         35
`define LTC_ISO_POS         39

`endif

// >>> rtl/ltc_pkg.sv
`default_nettype none

package ltc_pkg;

  typedef logic [47:0] ltc_word_t;

  // Turn-on slew codes
  typedef enum logic [1:0] {
    LTC_RISE_SLOWER = 2'h0,
    LTC_RISE_SLOW   = 2'h1,
    LTC_RISE_FAST   = 2'h2,
    LTC_RISE_FASTER = 2'h3
  } ltc_rise_e;

  // Threshold codes, 0.2 V upward in eight steps
  typedef logic [2:0] ltc_thr_t;

endpackage : ltc_pkg

`default_nettype wire

// >>> rtl/ltc_regs.sv
// Local design decisions: the address map and the APB register port.
`include "ltc_defines.svh"
`default_nettype none

module ltc_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Short detection comparators
  output ltc_pkg::ltc_thr_t        red_short_threshold,
  output ltc_pkg::ltc_thr_t        green_short_threshold,
  output ltc_pkg::ltc_thr_t        blue_short_threshold,
  // Current sources
  output logic                     channel_current_ceiling,
  output logic [2:0]               fine_range_en,
  output logic [2:0]               coarse_range_en,
  output logic                     red_falling_edge_rate,
  output logic                     green_falling_edge_rate,
  output logic                     blue_falling_edge_rate,
  output ltc_pkg::ltc_rise_e       red_rising_edge_rate,
  output ltc_pkg::ltc_rise_e       green_rising_edge_rate,
  output ltc_pkg::ltc_rise_e       blue_rising_edge_rate,
  output logic                     on_off_channel_isolation,
  // Scan and memory sequencing
  output logic                     panel_dimension_select,
  output logic                     upper_line_order_flip,
  output logic                     upper_line_order_active,
  output logic [3:0]               first_line_dim
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  function automatic logic [31:0] strb_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : strb_mask

  // Merge one APB word into a 48-bit register half.
  // Bits outside the mask keep their reset pattern forever.
  function automatic ltc_pkg::ltc_word_t upd48(
    input ltc_pkg::ltc_word_t cur,
    input ltc_pkg::ltc_word_t wmask,
    input logic               hi,
    input logic [31:0]        wd,
    input logic [3:0]         be
  );
    logic [31:0]        bm32;
    ltc_pkg::ltc_word_t bm;
    ltc_pkg::ltc_word_t val;
    bm32 = strb_mask(be);
    if (hi) begin
      bm  = {bm32[15:0], 32'h0000_0000};
      val = {wd[15:0], 32'h0000_0000};
    end else begin
      bm  = {16'h0000, bm32};
      val = {16'h0000, wd};
    end
    bm = bm & wmask;
    return (cur & ~bm) | (val & bm);
  endfunction : upd48

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  ltc_pkg::ltc_word_t prot_cfg_ff;
  ltc_pkg::ltc_word_t drive_cfg_ff;
  logic               panel_ff;
  logic [31:0]        rdata_ff;
  logic               data_ok_ff;
  logic               order_active_ff;

  ltc_pkg::ltc_word_t nxt_prot_cfg;
  ltc_pkg::ltc_word_t nxt_drive_cfg;
  logic               nxt_panel;
  logic [31:0]        nxt_rdata;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  logic sel_prot_lo;
  logic sel_prot_hi;
  logic sel_drv_lo;
  logic sel_drv_hi;
  logic sel_panel;
  logic sel_status;
  logic addr_hit;
  logic access;
  logic wr_take;

  assign sel_prot_lo = (paddr == ADDR_W'(`LTC_PROT_LO_OFS));
  assign sel_prot_hi = (paddr == ADDR_W'(`LTC_PROT_HI_OFS));
  assign sel_drv_lo  = (paddr == ADDR_W'(`LTC_DRV_LO_OFS));
  assign sel_drv_hi  = (paddr == ADDR_W'(`LTC_DRV_HI_OFS));
  assign sel_panel   = (paddr == ADDR_W'(`LTC_PANEL_OFS));
  assign sel_status  = (paddr == ADDR_W'(`LTC_STATUS_OFS));

  assign addr_hit = sel_prot_lo | sel_prot_hi | sel_drv_lo
                  | sel_drv_hi | sel_panel | sel_status;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------

  // Read data is captured from the flops one cycle ahead, so the
  // access phase waits if the enable was low during setup.
  assign access  = psel & penable;
  assign pready  = clk_en & data_ok_ff;
  assign pslverr = access & ~addr_hit;
  assign wr_take = access & pready & pwrite & addr_hit;
  assign prdata  = rdata_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_ok_ff <= 1'b0;
    end else if (clk_en) begin
      data_ok_ff <= psel & ~(access & pready);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (sel_prot_lo) begin
      nxt_rdata = prot_cfg_ff[31:0];                          // [RULE13]
    end else if (sel_prot_hi) begin
      nxt_rdata = {16'h0000, prot_cfg_ff[47:32]};             // [RULE13]
    end else if (sel_drv_lo) begin
      nxt_rdata = drive_cfg_ff[31:0];                         // [RULE13]
    end else if (sel_drv_hi) begin
      nxt_rdata = {16'h0000, drive_cfg_ff[47:32]};            // [RULE13]
    end else if (sel_panel) begin
      nxt_rdata = {31'h0000_0000, panel_ff};
    end else if (sel_status) begin
      nxt_rdata = {31'h0000_0000, upper_line_order_active};
    end
  end

  // Unmapped reads return zero alongside the error flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en && psel && !data_ok_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Protection and brightness word
  // ----------------------------------------------------------------

  always_comb begin
    nxt_prot_cfg = prot_cfg_ff;
    if (wr_take && sel_prot_lo) begin
      nxt_prot_cfg = upd48(prot_cfg_ff, `LTC_PROT_WMASK, 1'b0,
                           pwdata, pstrb);                    // [RULE13]
    end else if (wr_take && sel_prot_hi) begin
      nxt_prot_cfg = upd48(prot_cfg_ff, `LTC_PROT_WMASK, 1'b1,
                           pwdata, pstrb);                    // [RULE13]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prot_cfg_ff <= `LTC_PROT_RST;             // [RULE1] [RULE2] [RULE3]
    end else if (clk_en) begin
      prot_cfg_ff <= nxt_prot_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Drive shaping word
  // ----------------------------------------------------------------

  always_comb begin
    nxt_drive_cfg = drive_cfg_ff;
    if (wr_take && sel_drv_lo) begin
      nxt_drive_cfg = upd48(drive_cfg_ff, `LTC_DRV_WMASK, 1'b0,
                            pwdata, pstrb);                   // [RULE13]
    end else if (wr_take && sel_drv_hi) begin
      nxt_drive_cfg = upd48(drive_cfg_ff, `LTC_DRV_WMASK, 1'b1,
                            pwdata, pstrb);                   // [RULE13]
    end
  end

  // Reset gives flip set, turn-on slew 01 and reserved 3Ch pattern
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_cfg_ff <= `LTC_DRV_RST;             // [RULE5] [RULE8]
    end else if (clk_en) begin
      drive_cfg_ff <= nxt_drive_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Panel size
  // ----------------------------------------------------------------

  always_comb begin
    nxt_panel = panel_ff;
    if (wr_take && sel_panel && pstrb[0]) begin
      nxt_panel = pwdata[0];                                  // [RULE12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      panel_ff <= `LTC_PANEL_RST;
    end else if (clk_en) begin
      panel_ff <= nxt_panel;
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------

  // Outputs are straight slices of the flops: a write is seen by
  // the analog side on the cycle after the access edge.
  assign red_short_threshold =
    prot_cfg_ff[`LTC_RED_THR_POS +: 3];                       // [RULE1]
  assign green_short_threshold =
    prot_cfg_ff[`LTC_GRN_THR_POS +: 3];                       // [RULE2]
  assign blue_short_threshold =
    prot_cfg_ff[`LTC_BLU_THR_POS +: 3];                       // [RULE3]

  assign channel_current_ceiling =
    drive_cfg_ff[`LTC_CEIL_POS];                              // [RULE4]
  assign upper_line_order_flip =
    drive_cfg_ff[`LTC_FLIP_POS];                              // [RULE5]
  assign fine_range_en =
    drive_cfg_ff[`LTC_FINE_POS +: 3];                         // [RULE6]

  assign red_falling_edge_rate =
    drive_cfg_ff[`LTC_FALL_POS];                              // [RULE7]
  assign green_falling_edge_rate =
    drive_cfg_ff[`LTC_FALL_POS + 1];                          // [RULE7]
  assign blue_falling_edge_rate =
    drive_cfg_ff[`LTC_FALL_POS + 2];                          // [RULE7]

  assign red_rising_edge_rate = ltc_pkg::ltc_rise_e'(
    drive_cfg_ff[`LTC_RISE_R_POS +: 2]);                      // [RULE8]
  assign green_rising_edge_rate = ltc_pkg::ltc_rise_e'(
    drive_cfg_ff[`LTC_RISE_G_POS +: 2]);                      // [RULE8]
  assign blue_rising_edge_rate = ltc_pkg::ltc_rise_e'(
    drive_cfg_ff[`LTC_RISE_B_POS +: 2]);                      // [RULE8]

  assign coarse_range_en =
    drive_cfg_ff[`LTC_COARSE_POS +: 3];                       // [RULE9]
  assign first_line_dim =
    drive_cfg_ff[`LTC_DIM_POS +: 4];                          // [RULE10]
  assign on_off_channel_isolation =
    drive_cfg_ff[`LTC_ISO_POS];                               // [RULE11]

  // The flip only matters on a stacked panel; single panels have no
  // upper half to reorder.
  assign panel_dimension_select  = panel_ff;                  // [RULE14]

  // Registered from the next values so it lines up with its sources
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      order_active_ff <= 1'b0;
    end else if (clk_en) begin
      order_active_ff <= nxt_panel & nxt_drive_cfg[`LTC_FLIP_POS]; // [RULE12]
    end
  end

  assign upper_line_order_active = order_active_ff;

endmodule : ltc_regs

`default_nettype wire

// >>> verif/ltc_regs_properties.sv
`default_nettype none

// ------------------------------------------
// Register bank checks
// ------------------------------------------
module ltc_regs_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire ltc_pkg::ltc_thr_t red_short_threshold,
  input wire ltc_pkg::ltc_thr_t blue_short_threshold,
  input wire logic              channel_current_ceiling,
  input wire logic              upper_line_order_flip,
  input wire logic              upper_line_order_active,
  input wire logic              panel_dimension_select,
  input wire logic              on_off_channel_isolation,
  input wire logic [2:0]        coarse_range_en,
  input wire logic [3:0]        first_line_dim
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic bad_addr;
  assign bad_addr = (paddr > 8'h14) || (paddr[1:0] != 2'h0);
  sequence acc;
    psel && penable && pready;
  endsequence
  sequence wr(a, s);
    acc ##0 (pwrite && paddr == a && (pstrb & s) == s);
  endsequence
  sequence bad;
    psel && penable && bad_addr;
  endsequence
  AST_WR_THR: assert property (wr(8'h04, 4'h3) |=>
    red_short_threshold == $past(pwdata[9:7]) &&
    blue_short_threshold == $past(pwdata[15:13]))
    else $error("threshold write not applied");
  AST_WR_CEIL: assert property (wr(8'h08, 4'h3) |=>
    channel_current_ceiling == $past(pwdata[1]) &&
    upper_line_order_flip == $past(pwdata[14]))
    else $error("ceiling or flip write not applied");
  AST_WR_HI: assert property (wr(8'h0C, 4'h1) |=>
    first_line_dim == $past(pwdata[6:3]) &&
    on_off_channel_isolation == $past(pwdata[7]) &&
    coarse_range_en == $past(pwdata[2:0]))
    else $error("drive upper write not applied");
  AST_PANEL: assert property (wr(8'h10, 4'h1) |=>
    panel_dimension_select == $past(pwdata[0]) &&
    upper_line_order_active == ($past(pwdata[0]) && upper_line_order_flip))
    else $error("panel select wrong");
  AST_HOLD: assert property (!(psel && penable && pwrite) |=>
    $stable({red_short_threshold, blue_short_threshold, first_line_dim,
             channel_current_ceiling, upper_line_order_flip,
             on_off_channel_isolation, coarse_range_en}))
    else $error("field changed without a write");
  AST_BAD: assert property (bad |-> pslverr)
    else $error("unmapped access not refused");
  AST_BAD_RD: assert property (bad ##0 (!pwrite && pready) |->
    prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  AST_GOOD: assert property (
    psel && penable && !bad_addr |-> !pslverr)
    else $error("mapped access refused");
  AST_RD_THR: assert property (
    acc ##0 (!pwrite && paddr == 8'h04) |->
    prdata[9:7] == red_short_threshold && prdata[31:16] == 16'h0000)
    else $error("threshold readback wrong");
endmodule : ltc_regs_props

bind ltc_regs ltc_regs_props #(.ADDR_W(ADDR_W)) u_props (.*);

`default_nettype wire

// >>> verif/ltc_regs_bench.sv
`default_nettype none

module ltc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Field vector: thresholds, ceiling, fine, coarse, fall, rise, iso,
  // panel, flip, active, dim
  localparam logic [32:0] RST_F = {9'h0, 10'h0, 6'h15, 4'h2, 4'h0};
  logic               sys_clk = 1'b0;
  logic               rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         pstrb, dim;
  ltc_pkg::ltc_thr_t  thr_r, thr_g, thr_b;
  ltc_pkg::ltc_rise_e rise_r, rise_g, rise_b;
  logic [2:0]         fine, coarse;
  logic               ceil, fal_r, fal_g, fal_b, iso, panel, flip, act, er;
  logic [32:0]        flds;
  int                 err_total = 0;
  int                 tests_run = 0;
  assign flds = {thr_b, thr_g, thr_r, ceil, fine, coarse, fal_b, fal_g,
                 fal_r, rise_b, rise_g, rise_r, iso, panel, flip, act, dim};

  always #2 sys_clk = ~sys_clk;

  ltc_regs i_dut (.sys_clk, .rst_n, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .red_short_threshold(thr_r), .green_short_threshold(thr_g),
    .blue_short_threshold(thr_b), .channel_current_ceiling(ceil),
    .fine_range_en(fine), .coarse_range_en(coarse),
    .red_falling_edge_rate(fal_r), .green_falling_edge_rate(fal_g),
    .blue_falling_edge_rate(fal_b), .red_rising_edge_rate(rise_r),
    .green_rising_edge_rate(rise_g), .blue_rising_edge_rate(rise_b),
    .on_off_channel_isolation(iso), .panel_dimension_select(panel),
    .upper_line_order_flip(flip), .upper_line_order_active(act),
    .first_line_dim(dim));

  // ------------------------------------------
  // Bus and check tasks
  // ------------------------------------------
  task automatic chk(input string nm, input logic [47:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait states end when pready goes high; only the watchdog ends a stuck one
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic ee);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk("prdata", rd, e);
    chk("pslverr", er, ee);
  endtask : rd_chk

  task automatic fld_chk(input logic [32:0] e);
    @(negedge sys_clk);
    chk("fields", flds, e);
  endtask : fld_chk

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    clk_en = 1'b1;
    do_reset();
    rd_chk(8'h00, 32'h7F7F_7F00, 1'b0);
    rd_chk(8'h04, 32'h0000_003B, 1'b0);
    rd_chk(8'h08, 32'h0540_403C, 1'b0);
    rd_chk(8'h0C, 32'h0000_0800, 1'b0);
    fld_chk(RST_F);
    xfer(1'b1, 8'h04, 32'hFFFF_FFFF, 4'hF);
    xfer(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF);
    xfer(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
    fld_chk({9'h1FF, 10'h3FF, 6'h3F, 4'hA, 4'hF});
    rd_chk(8'h04, 32'h0000_FFFF, 1'b0);
    rd_chk(8'h08, 32'h0FFF_403E, 1'b0);
    rd_chk(8'h0C, 32'h0000_1FFF, 1'b0);
    xfer(1'b1, 8'h04, 32'h0000_8880, 4'hF);
    xfer(1'b1, 8'h08, 32'h0E11_0000, 4'hF);
    xfer(1'b1, 8'h0C, 32'h0000_0054, 4'hF);
    fld_chk({9'h111, 10'h062, 6'h38, 4'h0, 4'hA});
    xfer(1'b1, 8'h10, 32'h0000_0001, 4'hF);
    xfer(1'b1, 8'h08, 32'hFFFF_40FF, 4'h2);
    fld_chk({9'h111, 10'h062, 6'h38, 4'h7, 4'hA});
    rd_chk(8'h08, 32'h0E11_403C, 1'b0);
    xfer(1'b1, 8'h14, 32'h0, 4'hF);
    chk("pslverr", er, 1'b0);
    rd_chk(8'h14, 32'h0000_0001, 1'b0);
    rd_chk(8'h10, 32'h0000_0001, 1'b0);
    xfer(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
    chk("pslverr", er, 1'b1);
    rd_chk(8'h18, 32'h0, 1'b1);
    rd_chk(8'h02, 32'h0, 1'b1);
    clk_en <= 1'b0;
    fork
      rd_chk(8'h04, 32'h0000_8880, 1'b0);
      begin
        repeat (4) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    do_reset();
    fld_chk(RST_F);
    rd_chk(8'h08, 32'h0540_403C, 1'b0);
    rd_chk(8'h10, 32'h0000_0000, 1'b0);
    wrap_up();
  end

  // A stuck transfer would otherwise hang the run
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule : ltc_regs_bench

`default_nettype wire
